// [bsp_pkg.sv]
// Shared constants and types for the boundary-scan test port
package bsp_pkg;
  localparam int              IR_W       = 2;
  localparam logic [IR_W-1:0] OP_EXTEST  = 2'h0;
  localparam logic [IR_W-1:0] OP_SAMPLE  = 2'h1;
  localparam logic [IR_W-1:0] OP_BYPASS  = 2'h3;
  localparam logic [IR_W-1:0] IR_CAPT    = 2'h1;
  localparam int              CELLS      = 3;
  localparam int              CELL_IN    = 0;
  localparam int              CELL_OUT   = 1;
  localparam int              CELL_OE    = 2;
  localparam int              FIFO_DEPTH = 16;
  localparam int              N_PINS_DEF = 8;

  typedef enum logic [3:0] {
    ST_RESET  = 4'h0,
    ST_IDLE   = 4'h1,
    ST_SEL_DR = 4'h2,
    ST_CAP_DR = 4'h3,
    ST_SH_DR  = 4'h4,
    ST_EX1_DR = 4'h5,
    ST_PAU_DR = 4'h6,
    ST_EX2_DR = 4'h7,
    ST_UPD_DR = 4'h8,
    ST_SEL_IR = 4'h9,
    ST_CAP_IR = 4'ha,
    ST_SH_IR  = 4'hb,
    ST_EX1_IR = 4'hc,
    ST_PAU_IR = 4'hd,
    ST_EX2_IR = 4'he,
    ST_UPD_IR = 4'hf
  } bsp_tap_t;
endpackage

// [bsp_sync.sv]
// Two-stage synchroniser for a bus of independent levels
`timescale 1ns/1ps
module bsp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  if (W < 1) begin : g_chk
    $error("bsp_sync: W must be at least 1");
  end

  always_comb begin
    meta_d = d_i;
    sync_d = meta_q;
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q_o = sync_q;
endmodule

// [bsp_fifo.sv]
// Single-clock FIFO carrying update patterns to the pad drivers
`timescale 1ns/1ps
module bsp_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = bsp_pkg::FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  wr_d;
  logic [AW:0]  rd_q;
  logic [AW:0]  rd_d;
  logic         push;
  logic         pop;

  if (DEPTH < 2 || (1 << AW) != DEPTH || W < 1) begin : g_chk
    $error("bsp_fifo: DEPTH must be a power of two of at least 2");
  end

  always_comb begin
    out_valid_o = (wr_q != rd_q);
    in_ready_o  = (wr_q[AW-1:0] != rd_q[AW-1:0]) || (wr_q[AW] == rd_q[AW]);
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    wr_d        = push ? wr_q + 1'b1 : wr_q;
    rd_d        = pop ? rd_q + 1'b1 : rd_q;
    out_data_o  = mem_q[rd_q[AW-1:0]];
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage has no reset; an entry is only read after it was written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// [bsp_tap.sv]
// Boundary-scan test port: TAP controller, scan registers and pad control
`timescale 1ns/1ps
// Behaviour
// - Pads stay undriven until the power-good level is seen after reset.
// - Sixteen-state TAP controller driven by test clock and mode select.
// - Scan works before and after configuration, never during; user disable blocks it only after configuration.
// - Sample captures pin, core output and enable values; core keeps the pads.
// - Sample also preloads the update stage for a later external test.
// - External test drives pads from the update stage and captures pin inputs.
// - Bypass places a one-bit register between serial input and output.
module bsp_tap #(
  parameter int N_PINS = bsp_pkg::N_PINS_DEF,
  parameter int DEPTH  = bsp_pkg::FIFO_DEPTH
) (
  input  wire logic              ref_clk_i,
  input  wire logic              resetn_i,
  input  wire logic              tck_i,
  input  wire logic              tms_i,
  input  wire logic              tdi_i,
  output logic                   tdo_o,
  output logic                   tdo_oe_o,
  input  wire logic              pwr_good_i,
  input  wire logic              cfg_busy_i,
  input  wire logic              cfg_done_i,
  input  wire logic              user_scan_dis_i,
  input  wire logic [N_PINS-1:0] core_out_i,
  input  wire logic [N_PINS-1:0] core_oe_i,
  input  wire logic [N_PINS-1:0] pin_in_i,
  output logic      [N_PINS-1:0] pad_o,
  output logic      [N_PINS-1:0] pad_oe_o
);
  import bsp_pkg::*;

  localparam int BW = CELLS * N_PINS;
  localparam int SW = CELLS * N_PINS + 3;

  if (N_PINS < 1 || DEPTH < 2) begin : g_chk
    $error("bsp_tap: N_PINS must be at least 1 and DEPTH at least 2");
  end

  function automatic bsp_tap_t tap_next(input bsp_tap_t s, input logic m);
    case (s)
      ST_RESET:  tap_next = m ? ST_RESET : ST_IDLE;
      ST_IDLE:   tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR: tap_next = m ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  tap_next = m ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = m ? ST_UPD_DR : ST_PAU_DR;
      ST_PAU_DR: tap_next = m ? ST_EX2_DR : ST_PAU_DR;
      ST_EX2_DR: tap_next = m ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR: tap_next = m ? ST_RESET : ST_CAP_IR;
      ST_CAP_IR: tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  tap_next = m ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = m ? ST_UPD_IR : ST_PAU_IR;
      ST_PAU_IR: tap_next = m ? ST_EX2_IR : ST_PAU_IR;
      ST_EX2_IR: tap_next = m ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: tap_next = m ? ST_SEL_DR : ST_IDLE;
      default:   tap_next = ST_RESET;
    endcase
  endfunction

  // Only the two boundary instructions reach the boundary register
  function automatic logic bsr_sel(input logic [IR_W-1:0] ir);
    bsr_sel = (ir == OP_EXTEST) || (ir == OP_SAMPLE);
  endfunction

  // ---------------- Test clock domain ----------------
  logic              tck_rstn;
  logic [SW-1:0]     tsync;
  logic [BW-1:0]     snap;
  logic              scan_ok;
  bsp_tap_t          state_q, state_d;
  logic [IR_W-1:0]   ir_sh_q, ir_sh_d;
  logic [IR_W-1:0]   ir_q, ir_d;
  logic              byp_q, byp_d;
  logic [BW-1:0]     bsr_q, bsr_d;
  logic [BW-1:0]     upd_q, upd_d;
  logic              tgl_q, tgl_d;
  logic              extest_q, extest_d;
  logic              tdo_q, tdo_d;
  logic              tdo_oe_q, tdo_oe_d;

  // Test-clock reset: asserted at once, released on a test clock edge
  bsp_sync #(.W(1)) u_trst (
    .clk_i    (tck_i),
    .resetn_i (resetn_i),
    .d_i      (1'b1),
    .q_o      (tck_rstn)
  );

  bsp_sync #(.W(SW)) u_tsync (
    .clk_i    (tck_i),
    .resetn_i (tck_rstn),
    .d_i      ({user_scan_dis_i, cfg_done_i, cfg_busy_i, core_oe_i, core_out_i, pin_in_i}),
    .q_o      (tsync)
  );

  for (genvar p = 0; p < N_PINS; p++) begin : g_snap
    assign snap[CELLS*p+CELL_IN]  = tsync[p];
    assign snap[CELLS*p+CELL_OUT] = tsync[N_PINS+p];
    assign snap[CELLS*p+CELL_OE]  = tsync[2*N_PINS+p];
  end

  // Blocked while configuring, and after configuration when disabled
  assign scan_ok = !tsync[BW] && !(tsync[BW+1] && tsync[BW+2]);

  always_comb begin
    state_d  = scan_ok ? tap_next(state_q, tms_i) : ST_RESET;
    ir_sh_d  = ir_sh_q;
    ir_d     = ir_q;
    byp_d    = byp_q;
    bsr_d    = bsr_q;
    upd_d    = upd_q;
    tgl_d    = tgl_q;
    case (state_q)
      ST_RESET: begin
        ir_d = OP_BYPASS;
      end
      ST_CAP_IR: begin
        ir_sh_d = IR_CAPT;
      end
      ST_SH_IR: begin
        ir_sh_d = {tdi_i, ir_sh_q[IR_W-1:1]};
      end
      ST_UPD_IR: begin
        ir_d = ir_sh_q;
      end
      ST_CAP_DR: begin
        if (bsr_sel(ir_q)) begin
          bsr_d = snap;
        end else begin
          byp_d = 1'b0;
        end
      end
      ST_SH_DR: begin
        if (bsr_sel(ir_q)) begin
          bsr_d = {tdi_i, bsr_q[BW-1:1]};
        end else begin
          byp_d = tdi_i;
        end
      end
      ST_UPD_DR: begin
        if (bsr_sel(ir_q)) begin
          upd_d = bsr_q;
          tgl_d = ~tgl_q;
        end
      end
      default: begin
      end
    endcase
    // Tracks the next instruction, so a stopped test clock still applies it
    extest_d = (ir_d == OP_EXTEST);
    tdo_oe_d = (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
    if (state_q == ST_SH_IR) begin
      tdo_d = ir_sh_q[0];
    end else if (bsr_sel(ir_q)) begin
      tdo_d = bsr_q[0];
    end else begin
      tdo_d = byp_q;
    end
  end

  always_ff @(posedge tck_i or negedge tck_rstn) begin
    if (!tck_rstn) begin
      state_q  <= ST_RESET;
      ir_sh_q  <= IR_CAPT;
      ir_q     <= OP_BYPASS;
      byp_q    <= 1'b0;
      bsr_q    <= '0;
      upd_q    <= '0;
      tgl_q    <= 1'b0;
      extest_q <= 1'b0;
    end else begin
      state_q  <= state_d;
      ir_sh_q  <= ir_sh_d;
      ir_q     <= ir_d;
      byp_q    <= byp_d;
      bsr_q    <= bsr_d;
      upd_q    <= upd_d;
      tgl_q    <= tgl_d;
      extest_q <= extest_d;
    end
  end

  // Serial output changes on the falling edge, as the controller expects
  always_ff @(negedge tck_i or negedge tck_rstn) begin
    if (!tck_rstn) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else begin
      tdo_q    <= tdo_d;
      tdo_oe_q <= tdo_oe_d;
    end
  end

  assign tdo_o    = tdo_q;
  assign tdo_oe_o = tdo_oe_q;

  // ---------------- Reference clock domain ----------------
  logic [2:0]          rsync;
  logic                pwr_ok;
  logic                extest_s;
  logic                tgl_p_q, tgl_p_d;
  logic                pend_q, pend_d;
  logic [2*N_PINS-1:0] push_word;
  logic                f_in_ready;
  logic                f_out_valid;
  logic [2*N_PINS-1:0] f_out_data;
  logic [2*N_PINS-1:0] drv_q, drv_d;
  logic [N_PINS-1:0]   pad_q, pad_d;
  logic [N_PINS-1:0]   pad_oe_q, pad_oe_d;

  bsp_sync #(.W(3)) u_rsync (
    .clk_i    (ref_clk_i),
    .resetn_i (resetn_i),
    .d_i      ({tgl_q, extest_q, pwr_good_i}),
    .q_o      (rsync)
  );
  assign pwr_ok   = rsync[0];
  assign extest_s = rsync[1];

  // Update word is stable while its toggle crosses, so it is read directly
  for (genvar p = 0; p < N_PINS; p++) begin : g_word
    assign push_word[p]        = upd_q[CELLS*p+CELL_OUT];
    assign push_word[N_PINS+p] = upd_q[CELLS*p+CELL_OE];
  end

  // Pads stall the drain while power is not good, so the FIFO backs up
  bsp_fifo #(.W(2*N_PINS), .DEPTH(DEPTH)) u_fifo (
    .clk_i       (ref_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (pend_q),
    .in_ready_o  (f_in_ready),
    .in_data_i   (push_word),
    .out_valid_o (f_out_valid),
    .out_ready_i (pwr_ok),
    .out_data_o  (f_out_data)
  );

  always_comb begin
    tgl_p_d  = rsync[2];
    // A new update while one is pending wins over the push that clears it
    pend_d   = (pend_q && !f_in_ready) || (rsync[2] != tgl_p_q);
    drv_d    = (f_out_valid && pwr_ok) ? f_out_data : drv_q;
    pad_d    = '0;
    pad_oe_d = '0;
    if (pwr_ok) begin
      if (extest_s) begin
        pad_d    = drv_q[N_PINS-1:0];
        pad_oe_d = drv_q[2*N_PINS-1:N_PINS];
      end else begin
        pad_d    = core_out_i;
        pad_oe_d = core_oe_i;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tgl_p_q  <= 1'b0;
      pend_q   <= 1'b0;
      drv_q    <= '0;
      pad_q    <= '0;
      pad_oe_q <= '0;
    end else begin
      tgl_p_q  <= tgl_p_d;
      pend_q   <= pend_d;
      drv_q    <= drv_d;
      pad_q    <= pad_d;
      pad_oe_q <= pad_oe_d;
    end
  end

  assign pad_o    = pad_q;
  assign pad_oe_o = pad_oe_q;

  // ---------------- Checks ----------------
  tms_reset_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    tms_i [*5] |=> state_q == ST_RESET)
    else $error("five mode-select highs did not reach reset");
  ir_capture_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    state_q == ST_CAP_IR |=> ir_sh_q == IR_CAPT)
    else $error("instruction capture pattern wrong");
  scan_block_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    !scan_ok |=> state_q == ST_RESET ##1 (!scan_ok || state_q != ST_SH_DR))
    else $error("controller left reset while scan blocked");
  sample_cap_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    state_q == ST_CAP_DR && bsr_sel(ir_q) |=> bsr_q == $past(snap))
    else $error("boundary capture missed the pin snapshot");
  preload_upd_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    state_q == ST_UPD_DR && bsr_sel(ir_q)
      |=> upd_q == $past(bsr_q) && tgl_q != $past(tgl_q))
    else $error("update stage did not take the shifted pattern");
  bypass_path_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    state_q == ST_SH_DR && !bsr_sel(ir_q) ##1 state_q == ST_SH_DR
      |-> byp_q == $past(tdi_i) && $stable(bsr_q))
    else $error("bypass bit did not follow serial input");
  unsup_bypass_a: assert property (@(posedge tck_i) disable iff (!tck_rstn)
    state_q == ST_UPD_IR && ir_sh_q == 2'h2 |=> !bsr_sel(ir_q))
    else $error("unsupported opcode did not select bypass");
  power_off_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    !pwr_ok |=> pad_oe_o == '0)
    else $error("pads driven before power good");
  extest_drive_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    pwr_ok && extest_s |=> pad_o == $past(drv_q[N_PINS-1:0]))
    else $error("external test pads not from update stage");
  sample_pass_a: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    pwr_ok && !extest_s |=> pad_o == $past(core_out_i) && pad_oe_o == $past(core_oe_i))
    else $error("core output disturbed outside external test");
endmodule

// [bsp_ctl_model.sv]
// Board test controller model driving the serial test port
`timescale 1ns/1ps
module bsp_ctl_model (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  input  wire logic tdo_oe_i
);
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b0;
  end

  // One test clock; tck rests low between frames, tdo is taken before the rise
  task automatic step(input logic m, input logic d, output logic o, output logic e);
    tms_o = m;
    tdi_o = d;
    #24;
    o     = tdo_i;
    e     = tdo_oe_i;
    tck_o = 1'b1;
    #24;
    tck_o = 1'b0;
    tdi_o = ~d;
  endtask

  task automatic tap_reset();
    logic o;
    logic e;
    repeat (8) step(1'b1, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
  endtask

  // Idle to shift, n bits LSB first, update, back to idle
  task automatic scan(input bit ir, input int n, input logic [31:0] din,
                      output logic [31:0] dout, output int oe_n);
    logic o;
    logic e;
    dout = '0;
    oe_n = 0;
    step(1'b1, 1'b0, o, e);
    if (ir) step(1'b1, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o, e);
      dout[i] = o;
      if (e === 1'b1) oe_n++;
    end
    step(1'b1, 1'b0, o, e);
    step(1'b0, 1'b0, o, e);
  endtask
endmodule

// [tb.sv]
// Self-checking testbench for the boundary-scan test port
`timescale 1ns/1ps
module tb;
  import bsp_pkg::*;
  localparam int N  = N_PINS_DEF;
  localparam int BL = CELLS * N;
  logic          ref_clk_i, resetn_i, tck, tms, tdi, tdo, tdo_oe;
  logic          pwr_good_i, cfg_busy_i, cfg_done_i, user_scan_dis_i;
  logic [N-1:0]  core_out_i, core_oe_i, pin_in_i, pad_o, pad_oe_o;
  logic [31:0]   rng, din, dout, pre;
  logic [2:0]    cfg_tbl [3];
  int            fail_count, checks, cyc, oe_n;

  bsp_tap #(.N_PINS(N), .DEPTH(FIFO_DEPTH)) dut_u (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .tck_i(tck), .tms_i(tms),
    .tdi_i(tdi), .tdo_o(tdo), .tdo_oe_o(tdo_oe), .pwr_good_i(pwr_good_i),
    .cfg_busy_i(cfg_busy_i), .cfg_done_i(cfg_done_i),
    .user_scan_dis_i(user_scan_dis_i), .core_out_i(core_out_i),
    .core_oe_i(core_oe_i), .pin_in_i(pin_in_i), .pad_o(pad_o), .pad_oe_o(pad_oe_o));

  bsp_ctl_model ctl_u (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo),
                       .tdo_oe_i(tdo_oe));

  always #2.5 ref_clk_i = ~ref_clk_i;

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // Bypass stage: one captured zero, then every bit one clock late
  function automatic logic [31:0] byp_exp(input logic [31:0] d, input int n);
    bit          q[$];
    logic [31:0] r;
    r = '0;
    q.push_back(1'b0);
    for (int i = 0; i < n; i++) begin
      q.push_back(d[i]);
      r[i] = q.pop_front();
    end
    return r;
  endfunction

  // Cells per pin: input, output value, output enable
  function automatic logic [31:0] cap_exp(input logic [N-1:0] p, v, e);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      r[CELLS*i+CELL_IN]  = p[i];
      r[CELLS*i+CELL_OUT] = v[i];
      r[CELLS*i+CELL_OE]  = e[i];
    end
    return r;
  endfunction

  function automatic logic [31:0] in_mask();
    return cap_exp('1, '0, '0);
  endfunction

  function automatic logic [31:0] pads_of(input logic [31:0] c);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < N; i++) begin
      r[i]     = c[CELLS*i+CELL_OUT];
      r[N + i] = c[CELLS*i+CELL_OE];
    end
    return r;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic settle();
    repeat (12) @(negedge ref_clk_i);
  endtask

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    ref_clk_i = 1'b0;
    resetn_i = 1'b0;
    {pwr_good_i, cfg_busy_i, cfg_done_i, user_scan_dis_i} = 4'h0;
    rng = 32'hb018;
    fail_count = 0;
    checks = 0;
    cyc = 0;
    core_out_i = rng[N-1:0];
    core_oe_i = '1;
    pin_in_i = rng[15:8];
    cfg_tbl = '{3'b100, 3'b011, 3'b010};
    repeat (3) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    ctl_u.tap_reset();
    settle();
    check(pad_oe_o, '0);
    pwr_good_i = 1'b1;
    settle();
    check({pad_oe_o, pad_o}, {core_oe_i, core_out_i});
    for (int op = 3; op >= 0; op--) begin
      ctl_u.scan(1'b1, IR_W, op, dout, oe_n);
      check(dout, IR_CAPT);
      settle();
      if (op == 0) check({pad_oe_o, pad_o}, pads_of(pre));
      rng = xs(rng);
      din = rng & 32'h00ffffff;
      ctl_u.scan(1'b0, BL, din, dout, oe_n);
      settle();
      if (op >= 2) check(dout, byp_exp(din, BL));
      if (op == 1) check(dout, cap_exp(pin_in_i, core_out_i, core_oe_i));
      if (op == 1) check({pad_oe_o, pad_o}, {core_oe_i, core_out_i});
      if (op == 0) check(dout & in_mask(), cap_exp(pin_in_i, '0, '0));
      if (op == 0) check({pad_oe_o, pad_o}, pads_of(din));
      pre = din;
    end
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk_i);
      {cfg_busy_i, cfg_done_i, user_scan_dis_i} = cfg_tbl[k];
      ctl_u.tap_reset();
      ctl_u.scan(1'b1, IR_W, OP_SAMPLE, dout, oe_n);
      check(oe_n, (k < 2) ? 0 : IR_W);
      if (k == 2) check(dout, IR_CAPT);
    end
    @(negedge ref_clk_i);
    pwr_good_i = 1'b0;
    ctl_u.scan(1'b1, IR_W, OP_EXTEST, dout, oe_n);
    for (int j = 0; j < FIFO_DEPTH + 2; j++) begin
      rng = xs(rng);
      @(negedge ref_clk_i);
      pin_in_i = rng[N-1:0];
      din = rng & 32'h00ffffff;
      ctl_u.scan(1'b0, BL, din, dout, oe_n);
      check(pad_oe_o, '0);
    end
    @(negedge ref_clk_i);
    pwr_good_i = 1'b1;
    repeat (60) @(negedge ref_clk_i);
    check({pad_oe_o, pad_o}, pads_of(din));
    give_verdict();
  end
endmodule
